/* File: pic_pkg.sv */
package pic_pkg;

   // ************************************************************
   // sizes
   // ************************************************************
   localparam int NUM_TRAPS = 8;
   localparam int NUM_GROUPS = 4;
   localparam int GRP_LEVELS = 24;
   localparam int NUM_EXT = 72;
   localparam int NUM_LEVELS = 80;
   localparam int IDX_W = 7;
   localparam int VEC_W = 8;

   // ************************************************************
   // trap level positions
   // ************************************************************
   localparam int TRAP_POWER = 0;
   localparam int TRAP_PARITY = 1;
   localparam int TRAP_PAGE_FAULT = 2;
   localparam int TRAP_INSTRUCTION = 3;
   localparam int TRAP_ADDRESS = 4;
   localparam int TRAP_STALL = 5;
   localparam int TRAP_INTERVAL_TIMER = 6;
   localparam int TRAP_ARITH_FLOW = 7;

   // traps 4, 6 and 7 obey hold and release
   localparam logic [NUM_TRAPS-1:0] TRAP_HOLDABLE = 8'hd0;

   // ************************************************************
   // dedicated locations: octal 60 plus the flat level index
   // ************************************************************
   localparam logic [VEC_W-1:0] VEC_BASE = 8'h30;

   // ************************************************************
   // level population options
   // ************************************************************
   localparam logic [1:0] POP_BASE = 2'h0;
   localparam logic [1:0] POP_EXP1 = 2'h1;
   localparam logic [1:0] POP_EXP2 = 2'h2;
   localparam logic [NUM_LEVELS-1:0] POP_MASK_BASE = 80'h0000_0000_0000_00ff_ffff;
   localparam logic [NUM_LEVELS-1:0] POP_MASK_EXP1 = 80'h0000_00ff_ffff_ffff_ffff;
   localparam logic [NUM_LEVELS-1:0] POP_MASK_EXP2 = 80'hffff_ffff_ffff_ffff_ffff;

   // ************************************************************
   // reset values
   // ************************************************************
   localparam logic [GRP_LEVELS-1:0] RST_ARM = 24'h000000;
   localparam logic [GRP_LEVELS-1:0] RST_ENABLE = 24'h000000;
   localparam logic [NUM_LEVELS-1:0] RST_LEVELS = 80'h0;

   // ************************************************************
   // carriers
   // ************************************************************
   typedef struct packed {
      logic valid;
      logic [1:0] grp;
      logic [GRP_LEVELS-1:0] aBits;
      logic [GRP_LEVELS-1:0] eBits;
   } pic_grp_wr_t;

   typedef struct packed {
      logic [GRP_LEVELS-1:0] arm;
      logic [GRP_LEVELS-1:0] enable;
      logic [GRP_LEVELS-1:0] request;
      logic [GRP_LEVELS-1:0] active;
   } pic_grp_rd_t;

   typedef struct packed {
      logic valid;
      logic [VEC_W-1:0] vector;
      logic [IDX_W-1:0] level;
   } pic_divert_t;

endpackage

/* File: pic_trig_sync.sv */
`timescale 1ns/1ns

// ************************************************************
// two-flop synchroniser with rising edge pulse
// ************************************************************
module pic_trig_sync
   import pic_pkg::*;
#(
   parameter int W = NUM_EXT
) (
   input wire logic ref_clk,
   input wire logic rstn,
   input wire logic clkEn,
   input wire logic [W-1:0] trigIn,
   output logic [W-1:0] risePulse
);

   logic [W-1:0] meta_q;
   logic [W-1:0] sync_q;
   logic [W-1:0] last_q;
   logic [W-1:0] rise_q;

   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         meta_q <= '0;
         sync_q <= '0;
      end else if (clkEn) begin
         meta_q <= trigIn;
         sync_q <= meta_q;
      end
   end

   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         last_q <= '0;
         rise_q <= '0;
      end else if (clkEn) begin
         last_q <= sync_q;
         rise_q <= sync_q & ~last_q;
      end
   end

   assign risePulse = rise_q;

endmodule

/* File: pic_prio_enc.sv */
`timescale 1ns/1ns

// ************************************************************
// lowest index wins
// ************************************************************
module pic_prio_enc
   import pic_pkg::*;
(
   input wire logic [NUM_LEVELS-1:0] reqVec,
   output logic found,
   output logic [IDX_W-1:0] idx
);

   always_comb begin
      found = 1'b0;
      idx = '0;
      for (int i = NUM_LEVELS - 1; i >= 0; i--) begin
         if (reqVec[i]) begin
            found = 1'b1;
            idx = IDX_W'(i);
         end
      end
   end

endmodule

/* File: pic_priority_interrupt_controller.sv */
`timescale 1ns/1ns

module pic_priority_interrupt_controller
   import pic_pkg::*;
(
   input wire logic ref_clk,
   input wire logic rstn,
   input wire logic clkEn,
   input wire logic [1:0] popCfg,
   input wire logic [NUM_TRAPS-1:0] trapTrig,
   input wire logic [NUM_EXT-1:0] extTrig,
   input wire logic instrDone,
   input wire logic serviceDone,
   input wire logic [IDX_W-1:0] doneLevel,
   input wire logic hold_external_interrupts,
   input wire logic release_external_interrupts,
   input wire pic_grp_wr_t grpCtl,
   input wire pic_grp_wr_t grpSoft,
   input wire logic [1:0] rdSel,
   output pic_divert_t divert,
   output pic_grp_rd_t grpStatus,
   output logic holdState
);

   // ************************************************************
   // helpers
   // ************************************************************
   // code 3 also gives the full population
   function automatic logic [NUM_LEVELS-1:0] popMask(input logic [1:0] cfg);
      logic [NUM_LEVELS-1:0] m;
      m = POP_MASK_BASE;
      if (cfg == POP_EXP1) begin
         m = POP_MASK_EXP1;
      end else if (cfg >= POP_EXP2) begin
         m = POP_MASK_EXP2;
      end
      return m;
   endfunction

   // offset of a group's level 0 in the flat index
   function automatic int grpBase(input logic [1:0] g);
      return NUM_TRAPS + GRP_LEVELS * (int'(g) - 1);
   endfunction

   // place a group word at its flat index, bit n for level n
   function automatic logic [NUM_LEVELS-1:0] grpPlace(input logic [1:0] g,
                                                      input logic [GRP_LEVELS-1:0] v);
      logic [NUM_LEVELS-1:0] r;
      r = '0;
      if (g == 2'h0) begin
         r[NUM_TRAPS-1:0] = v[NUM_TRAPS-1:0];
      end else begin
         r = NUM_LEVELS'(v) << grpBase(g);
      end
      return r;
   endfunction

   function automatic logic [GRP_LEVELS-1:0] grpPick(input logic [1:0] g,
                                                     input logic [NUM_LEVELS-1:0] v);
      logic [GRP_LEVELS-1:0] r;
      r = '0;
      if (g == 2'h0) begin
         r[NUM_TRAPS-1:0] = v[NUM_TRAPS-1:0];
      end else begin
         r = GRP_LEVELS'(v >> grpBase(g));
      end
      return r;
   endfunction

   // a group word aimed at group 1 to 3
   function automatic logic extGrpHit(input pic_grp_wr_t w);
      return w.valid && w.grp != 2'h0;
   endfunction

   // one flat level as a mask
   function automatic logic [NUM_LEVELS-1:0] levelBit(input logic [IDX_W-1:0] i);
      return NUM_LEVELS'(1) << i;
   endfunction

   // dedicated location of a flat level
   function automatic logic [VEC_W-1:0] levelVec(input logic [IDX_W-1:0] i);
      return VEC_BASE + VEC_W'(i);
   endfunction

   // ************************************************************
   // declarations
   // ************************************************************
   logic [GRP_LEVELS-1:0] arm_q [1:NUM_GROUPS-1];
   logic [GRP_LEVELS-1:0] enable_q [1:NUM_GROUPS-1];
   logic [NUM_LEVELS-1:0] request_q;
   logic [NUM_LEVELS-1:0] request_d;
   logic [NUM_LEVELS-1:0] active_q;
   logic [NUM_LEVELS-1:0] active_d;
   logic [NUM_TRAPS-1:0] trapLast_q;
   logic hold_q;
   pic_divert_t divert_q;
   pic_grp_rd_t status_q;

   logic [NUM_EXT-1:0] extRise;
   logic [NUM_TRAPS-1:0] trapEdge;
   logic [NUM_LEVELS-1:0] effArm;
   logic [NUM_LEVELS-1:0] effEnable;
   logic [NUM_LEVELS-1:0] present;
   logic [NUM_LEVELS-1:0] holdMask;
   logic [NUM_LEVELS-1:0] trigAll;
   logic [NUM_LEVELS-1:0] softReq;
   logic [NUM_LEVELS-1:0] softAct;
   logic [NUM_LEVELS-1:0] candVec;
   logic [NUM_LEVELS-1:0] blockVec;
   logic [NUM_LEVELS-1:0] takeMask;
   logic [NUM_LEVELS-1:0] doneMask;
   logic candFound;
   logic [IDX_W-1:0] candIdx;
   logic blockFound;
   logic [IDX_W-1:0] blockIdx;
   logic candIsTrap;
   logic outranks;
   logic extReady;
   logic take;

   // ************************************************************
   // trigger capture
   // ************************************************************
   pic_trig_sync #(
      .W(NUM_EXT)
   ) u_ext_sync (
      .ref_clk(ref_clk),
      .rstn(rstn),
      .clkEn(clkEn),
      .trigIn(extTrig),
      .risePulse(extRise)
   );

   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         trapLast_q <= '0;
      end else if (clkEn) begin
         trapLast_q <= trapTrig;
      end
   end

   // trap inputs are internal and already on this clock
   assign trapEdge = trapTrig & ~trapLast_q;

   // ************************************************************
   // per-group arm and enable registers
   // ************************************************************
   genvar g;
   generate
      for (g = 1; g < NUM_GROUPS; g++) begin : gen_grp
         always_ff @(posedge ref_clk or negedge rstn) begin
            if (!rstn) begin
               arm_q[g] <= RST_ARM;
               enable_q[g] <= RST_ENABLE;
            end else if (clkEn && grpCtl.valid && grpCtl.grp == 2'(g)) begin
               arm_q[g] <= grpCtl.aBits;
               enable_q[g] <= grpCtl.eBits;
            end
         end
      end
   endgenerate

   // traps are hardwired armed and enabled
   assign effArm = {arm_q[3], arm_q[2], arm_q[1], {NUM_TRAPS{1'b1}}};
   assign effEnable = {enable_q[3], enable_q[2], enable_q[1], {NUM_TRAPS{1'b1}}};

   // levels beyond the fitted population never fire
   assign present = popMask(popCfg);

   // ************************************************************
   // hold and release of external activation
   // ************************************************************
   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         hold_q <= 1'b0;
      end else if (clkEn) begin
         if (hold_external_interrupts) begin
            hold_q <= 1'b1;
         end else if (release_external_interrupts) begin
            hold_q <= 1'b0;
         end
      end
   end

   assign holdMask = {{NUM_EXT{~hold_q}}, ~(TRAP_HOLDABLE & {NUM_TRAPS{hold_q}})};

   // ************************************************************
   // waiting state
   // ************************************************************
   assign trigAll = {extRise, trapEdge} & present;
   assign softReq = extGrpHit(grpSoft) ?
                    grpPlace(grpSoft.grp, grpSoft.eBits) : '0;
   assign softAct = extGrpHit(grpSoft) ?
                    grpPlace(grpSoft.grp, grpSoft.aBits) & present : '0;

   // a new trigger wins over the clear caused by activation
   always_comb begin
      request_d = (request_q & ~takeMask) | ((trigAll | softReq) & effArm);
   end

   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         request_q <= RST_LEVELS;
      end else if (clkEn) begin
         request_q <= request_d;
      end
   end

   // ************************************************************
   // priority resolution
   // ************************************************************
   assign candVec = request_q & effEnable & present & holdMask;

   // inhibited active levels are permissive and block nothing
   assign blockVec = active_q & effEnable;

   pic_prio_enc u_cand_enc (
      .reqVec(candVec),
      .found(candFound),
      .idx(candIdx)
   );

   pic_prio_enc u_block_enc (
      .reqVec(blockVec),
      .found(blockFound),
      .idx(blockIdx)
   );

   assign candIsTrap = candIdx < IDX_W'(NUM_TRAPS);

   // traps go active at once, external levels at instruction end
   assign outranks = !blockFound || candIdx < blockIdx;
   assign extReady = candIsTrap || instrDone;
   assign take = candFound && outranks && extReady;

   assign takeMask = take ? levelBit(candIdx) : '0;
   assign doneMask = serviceDone ? levelBit(doneLevel) : '0;

   // ************************************************************
   // active state
   // ************************************************************
   always_comb begin
      active_d = (active_q & ~doneMask) | takeMask | softAct;
   end

   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         active_q <= RST_LEVELS;
      end else if (clkEn) begin
         active_q <= active_d;
      end
   end

   // ************************************************************
   // diversion to the dedicated location
   // ************************************************************
   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         divert_q <= '0;
      end else if (clkEn) begin
         divert_q.valid <= take;
         if (take) begin
            divert_q.vector <= levelVec(candIdx);
            divert_q.level <= candIdx;
         end
      end
   end

   // ************************************************************
   // status readback
   // ************************************************************
   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         status_q <= '0;
      end else if (clkEn) begin
         status_q.arm <= grpPick(rdSel, effArm);
         status_q.enable <= grpPick(rdSel, effEnable);
         status_q.request <= grpPick(rdSel, request_q);
         status_q.active <= grpPick(rdSel, active_q);
      end
   end

   assign divert = divert_q;
   assign grpStatus = status_q;
   assign holdState = hold_q;

endmodule

/* File: pic_priority_interrupt_controller_chk.sv */
`timescale 1ns/1ns
// ***
// divert and hold checks
// ***
module pic_priority_interrupt_controller_chk
   import pic_pkg::*;
(
   input wire logic ref_clk,
   input wire logic rstn,
   input wire logic clkEn,
   input wire logic [1:0] popCfg,
   input wire logic [NUM_TRAPS-1:0] trapTrig,
   input wire logic instrDone,
   input wire logic hold_external_interrupts,
   input wire logic release_external_interrupts,
   input wire pic_divert_t divert,
   input wire logic holdState
);
   default clocking cb @(posedge ref_clk);
   endclocking
   default disable iff (!rstn);
   vec_map_a: assert property (
      divert.valid |-> divert.vector == 8'h30 + {1'b0, divert.level})
      else $error("location and level disagree");
   div_keep_a: assert property (
      !divert.valid |-> $stable(divert.level) && $stable(divert.vector))
      else $error("divert fields moved without a divert");
   trap_fast_a: assert property (
      clkEn && $rose(trapTrig[0]) ##1 clkEn |=> divert.valid && divert.level == 7'h00)
      else $error("power trap not taken in time");
   ext_done_a: assert property (
      divert.valid && divert.level > 7'h07 |-> $past(instrDone) && $past(clkEn))
      else $error("external level taken mid instruction");
   hold_block_a: assert property (
      $past(holdState) && divert.valid |->
      divert.level < 7'h08 && !TRAP_HOLDABLE[divert.level[2:0]])
      else $error("held level taken");
   pop_limit_a: assert property (
      divert.valid |-> divert.level < ($past(popCfg) == 2'h0 ? 7'h18 :
      $past(popCfg) == 2'h1 ? 7'h38 : 7'h50))
      else $error("absent level taken");
   hold_set_a: assert property (
      hold_external_interrupts && clkEn |=> holdState)
      else $error("hold not set");
   hold_rel_a: assert property (
      release_external_interrupts && !hold_external_interrupts && clkEn |=> !holdState)
      else $error("hold not released");
endmodule
bind pic_priority_interrupt_controller pic_priority_interrupt_controller_chk u_chk (
   .ref_clk(ref_clk), .rstn(rstn), .clkEn(clkEn), .popCfg(popCfg), .trapTrig(trapTrig),
   .instrDone(instrDone), .hold_external_interrupts(hold_external_interrupts),
   .release_external_interrupts(release_external_interrupts), .divert(divert),
   .holdState(holdState)
);

/* File: pic_cpu_model.sv */
`timescale 1ns/1ns
// ***
// processor side model
// ***
module pic_cpu_model
   import pic_pkg::*;
(
   input wire logic ref_clk,
   input wire logic rstn,
   input wire logic slow,
   input wire pic_divert_t divert,
   output logic instrDone,
   output logic serviceDone,
   output logic [IDX_W-1:0] doneLevel
);
   logic [IDX_W-1:0] stk[$];
   int cnt;
   // nested service: last diverted level finishes first
   always @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         stk.delete();
         cnt = 0;
         instrDone <= 1'b0;
         serviceDone <= 1'b0;
         doneLevel <= '0;
      end else begin
         cnt++;
         instrDone <= slow ? (cnt % 4 == 0) : 1'b1;
         if (divert.valid === 1'b1) begin
            stk.push_back(divert.level);
            cnt = 0;
         end
         if (divert.valid !== 1'b1 && stk.size() > 0 && cnt > (slow ? 8 : 1)) begin
            serviceDone <= 1'b1;
            doneLevel <= stk.pop_back();
            cnt = 0;
         end else begin
            serviceDone <= 1'b0;
            doneLevel <= ~doneLevel;
         end
      end
   end
endmodule

/* File: pic_priority_interrupt_controller_tb_top.sv */
`timescale 1ns/1ns
// ***
// bench top
// ***
module pic_priority_interrupt_controller_tb_top
   import pic_pkg::*;
;
   logic ref_clk = 1'b0;
   logic rstn = 1'b0;
   logic clkEn = 1'b1;
   logic slow = 1'b0;
   logic [1:0] popCfg = 2'h2;
   logic [1:0] rdSel = 2'h0;
   logic [NUM_TRAPS-1:0] trapTrig = '0;
   logic [NUM_EXT-1:0] extTrig = '0;
   logic hold_external_interrupts = 1'b0;
   logic release_external_interrupts = 1'b0;
   pic_grp_wr_t grpCtl = '0;
   pic_grp_wr_t grpSoft = '0;
   logic instrDone;
   logic serviceDone;
   logic holdState;
   logic [IDX_W-1:0] doneLevel;
   pic_divert_t divert;
   pic_grp_rd_t grpStatus;
   logic [14:0] dq[$];
   logic [7:0] grpLoc [4] = '{8'h30, 8'h38, 8'h50, 8'h68};
   int bad_count = 0;
   int checked = 0;
   always #10 ref_clk = ~ref_clk;
   always @(posedge ref_clk) if (divert.valid === 1'b1) dq.push_back({divert.level, divert.vector});
   pic_priority_interrupt_controller u_pic_priority_interrupt_controller (
      .ref_clk(ref_clk), .rstn(rstn), .clkEn(clkEn), .popCfg(popCfg), .trapTrig(trapTrig),
      .extTrig(extTrig), .instrDone(instrDone), .serviceDone(serviceDone),
      .doneLevel(doneLevel), .hold_external_interrupts(hold_external_interrupts),
      .release_external_interrupts(release_external_interrupts), .grpCtl(grpCtl),
      .grpSoft(grpSoft), .rdSel(rdSel), .divert(divert), .grpStatus(grpStatus),
      .holdState(holdState)
   );
   pic_cpu_model u_pic_cpu_model (
      .ref_clk(ref_clk), .rstn(rstn), .slow(slow), .divert(divert), .instrDone(instrDone),
      .serviceDone(serviceDone), .doneLevel(doneLevel)
   );
   task automatic tick(input int n);
      repeat (n) @(posedge ref_clk);
   endtask
   task automatic tally_and_finish();
      $display("checks %0d errors %0d", checked, bad_count);
      if (bad_count == 0 && checked > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask
   task automatic cmp(input logic [23:0] got, input logic [23:0] exp);
      checked++;
      if (got !== exp) begin
         bad_count++;
         $display("wrong value at %0t: got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic setGrp(input int g, input logic [23:0] a, input logic [23:0] e);
      @(posedge ref_clk) grpCtl <= '{1'b1, 2'(g), a, e};
      @(posedge ref_clk) grpCtl.valid <= 1'b0;
   endtask
   task automatic fire(input logic trap, input int i);
      @(posedge ref_clk);
      if (trap) trapTrig[i] <= 1'b1;
      else extTrig[i] <= 1'b1;
      @(posedge ref_clk);
      trapTrig <= '0;
      extTrig <= '0;
   endtask
   task automatic expDiv(input int lvl, input logic [7:0] vec);
      logic [14:0] d;
      int n = 0;
      while (dq.size() == 0 && n < 60) begin
         tick(1);
         n++;
      end
      if (dq.size() == 0) begin
         bad_count++;
         tally_and_finish();
      end else begin
         d = dq.pop_front();
         cmp(24'(d[14:8]), 24'(lvl));
         cmp(24'(d[7:0]), 24'(vec));
      end
   endtask
   task automatic noDiv(input int n);
      tick(n);
      cmp(24'(dq.size()), 24'h0);
   endtask
   initial begin
      tick(2);
      rstn <= 1'b1;
      tick(3);
      cmp(grpStatus.arm, 24'h0000ff);
      cmp(grpStatus.enable, 24'h0000ff);
      rdSel <= 2'h1;
      tick(2);
      cmp(grpStatus.arm, 24'h000000);
      slow <= 1'b1;
      trapTrig <= 8'h24;
      tick(1);
      trapTrig <= 8'h00;
      expDiv(2, 8'h32);
      expDiv(5, 8'h35);
      slow <= 1'b0;
      setGrp(1, 24'h000000, 24'hffffff);
      fire(0, 3);
      noDiv(10);
      setGrp(1, 24'h000008, 24'h000000);
      fire(0, 3);
      noDiv(10);
      cmp(grpStatus.request, 24'h000008);
      setGrp(1, 24'h000008, 24'h000008);
      expDiv(11, 8'h3b);
      for (int g = 1; g < 4; g++) begin
         setGrp(g, 24'hffffff, 24'hffffff);
         for (int l = 0; l < 24; l += 23) begin
            fire(0, (g - 1) * 24 + l);
            expDiv(8 + (g - 1) * 24 + l, grpLoc[g] + 8'(l));
         end
      end
      popCfg <= 2'h1;
      fire(0, 48);
      noDiv(10);
      fire(0, 30);
      expDiv(38, 8'h56);
      popCfg <= 2'h0;
      fire(0, 16);
      noDiv(10);
      popCfg <= 2'h3;
      fire(0, 48);
      expDiv(56, 8'h68);
      hold_external_interrupts <= 1'b1;
      tick(1);
      hold_external_interrupts <= 1'b0;
      tick(1);
      cmp(24'(holdState), 24'h1);
      fire(0, 3);
      fire(1, 6);
      noDiv(10);
      fire(1, 0);
      expDiv(0, 8'h30);
      release_external_interrupts <= 1'b1;
      tick(1);
      release_external_interrupts <= 1'b0;
      expDiv(6, 8'h36);
      expDiv(11, 8'h3b);
      grpSoft <= '{1'b1, 2'h1, 24'h000000, 24'h000002};
      tick(1);
      grpSoft.valid <= 1'b0;
      expDiv(9, 8'h39);
      noDiv(10);
      clkEn <= 1'b0;
      hold_external_interrupts <= 1'b1;
      tick(1);
      hold_external_interrupts <= 1'b0;
      tick(1);
      cmp(24'(holdState), 24'h0);
      clkEn <= 1'b1;
      tally_and_finish();
   end
endmodule
